//--- logic/pmc_pkg.sv
// Shared constants for the port pin mode control block
package pmc_pkg;

  // Pin count and pin positions in the pin vectors
  localparam int          NPIN      = 12;   // PA0..PA6, pin seven, PB0..PB3
  localparam int          PIN_IRQ0  = 0;    // PA0 carries ext_irq_zero
  localparam int          PIN_PWA   = 1;    // PA1 carries pulse_out_a
  localparam int          PIN_PWB   = 3;    // PA3 carries pulse_out_b / scaled clock
  localparam int          PIN_SEVEN = 7;    // port_a_pin_seven
  localparam int          PIN_IRQ1  = 8;    // PB0 carries ext_irq_one

  // Register byte offsets on the APB
  localparam logic [7:0]  ADDR_DATA  = 8'h00;  // Data, reads pin state
  localparam logic [7:0]  ADDR_LATCH = 8'h04;  // Data, reads output latch
  localparam logic [7:0]  ADDR_MODE  = 8'h08;  // Two mode bits per pin
  localparam logic [7:0]  ADDR_ALT   = 8'h0c;  // Alternate function control
  localparam logic [7:0]  ADDR_STAT  = 8'h10;  // Sticky event status, W1C
  localparam logic [7:0]  ADDR_MASK  = 8'h14;  // Interrupt enables

  // Alternate control field positions
  localparam int          ALT_W    = 6;
  localparam int          ALT_PWA  = 0;   // pulse_out_a_enable
  localparam int          ALT_PWB  = 1;   // pulse_out_b_enable
  localparam int          ALT_TCO  = 2;   // scaled_clock_out_enable
  localparam int          ALT_XRST = 3;   // ext_reset_enable
  localparam int          ALT_XTAL = 4;   // Crystal pins taken by oscillator
  localparam int          ALT_EDG0 = 5;   // ext_irq_zero on rising edge

  // Status and mask field positions
  localparam int          ST_W     = 4;
  localparam int          ST_IRQ0  = 0;
  localparam int          ST_IRQ1  = 1;
  localparam int          ST_IRQ2  = 2;
  localparam int          ST_WAKE  = 3;

  // Reset values
  localparam logic [11:0] DATA_RST  = 12'hfff;
  localparam logic [23:0] MODE_RST  = 24'h004000;  // Pin seven field 01
  localparam logic [5:0]  ALT_RST   = 6'h00;
  localparam logic [3:0]  ST_RST    = 4'h0;
  localparam logic [11:0] XTAL_DEF  = 12'h060;     // PA5, PA6 as crystal pins

  // Pin modes
  typedef enum logic [1:0] {
    MODE_PU_IN    = 2'h0,
    MODE_FLOAT_IN = 2'h1,
    MODE_PUSH     = 2'h2,
    MODE_WAKE     = 2'h3
  } pmc_mode_e;

endpackage

//--- logic/pmc_pin_sync.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser; a level counts once stages two and three agree
module pmc_pin_sync
  import pmc_pkg::*;
#(
  parameter int           W       = NPIN,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] s1_r;   // Metastability stage, read only by s2_r
  logic [W-1:0] s2_r;   // Second stage
  logic [W-1:0] s3_r;   // Third stage
  logic [W-1:0] val_r;  // Accepted level

  // Shift chain and per-bit agreement filter
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_r  <= RST_VAL;
      s2_r  <= RST_VAL;
      s3_r  <= RST_VAL;
      val_r <= RST_VAL;
    end else begin
      s1_r  <= async_i;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      // Bits that disagree keep the old value
      val_r <= (s2_r & ~(s2_r ^ s3_r)) | (val_r & (s2_r ^ s3_r));
    end
  end

  assign sync_o = val_r;

endmodule

//--- logic/pmc_port.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Digital input only in input modes, data one
// [R2] Data zero drives low; data one follows mode
// [R3] Pull-up chosen per pin by its mode
// [R4] Read-modify-write reads return the output latch
// [R5] Ordinary data reads return pin state
// [R6] Bit ops and plane writes use latch read
// [R7] Alternate functions sit on fixed pins
// [R8] Alt outputs push-pull; interrupts need input setup
// [R9] Crystal pins override every other function
// [R10] Pin seven: input or open-drain low only
// [R11] Pin seven data one input, zero low
// [R12] Pin seven mode resets to pull-up off
// [R13] External reset makes pin seven pulled input
// [R14] Pin seven mode table without external reset
// [R15] Pin inputs synchronised before any use
module pmc_port
  import pmc_pkg::*;
#(
  parameter logic [NPIN-1:0] XTAL_MASK = XTAL_DEF
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic [7:0]       paddr_i,
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [31:0]      pwdata_i,
  output logic      [31:0]      prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  input  wire logic [NPIN-1:0]  pin_in_i,
  output logic      [NPIN-1:0]  pin_out_o,
  output logic      [NPIN-1:0]  pin_oe_o,
  output logic      [NPIN-1:0]  pin_pu_o,
  output logic      [NPIN-1:0]  pin_ie_o,
  input  wire logic             pulse_out_a_i,
  input  wire logic             pulse_out_b_i,
  input  wire logic             scaled_clock_out_i,
  output logic                  irq_o,
  output logic                  ext_reset_req_o
);

  // Register state
  logic [NPIN-1:0]   data_r;     // port_data_bit latch
  logic [2*NPIN-1:0] mode_r;     // Two bits per pin
  logic [ALT_W-1:0]  alt_r;      // Alternate function control
  logic [ST_W-1:0]   stat_r;     // Sticky events
  logic [ST_W-1:0]   mask_r;     // ext_irq_enable and wake enable
  logic [31:0]       prdata_r;   // Read data, loaded in setup phase
  logic [NPIN-1:0]   prev_r;     // Previous gated input level

  // Pin drive state
  logic [NPIN-1:0]   out_r;
  logic [NPIN-1:0]   oe_r;
  logic [NPIN-1:0]   pu_r;
  logic [NPIN-1:0]   ie_r;
  logic [3:0]        cfg_nxt [NPIN];  // {oe, out, pu, ie} per pin

  // Input side
  logic [NPIN-1:0]   pin_s;      // Synchronised pin levels
  logic [NPIN-1:0]   in_v;       // Levels seen through the input gate
  logic [NPIN-1:0]   fall;       // Falling edges
  logic [NPIN-1:0]   rise;       // Rising edges
  logic [NPIN-1:0]   wk_en;      // Pins armed for wakeup
  logic [ST_W-1:0]   ev;         // Events this cycle
  logic [ST_W-1:0]   clr;        // Software clears this cycle

  // Bus strobes
  logic              wr_en;
  logic              rd_setup;

  // True for a mapped register offset
  function automatic logic addr_ok(input logic [7:0] a);
    return (a == ADDR_DATA) || (a == ADDR_LATCH) || (a == ADDR_MODE) ||
           (a == ADDR_ALT)  || (a == ADDR_STAT)  || (a == ADDR_MASK);
  endfunction

  // Pin drive decode, returns {oe, out, pu, ie}
  function automatic logic [3:0] pin_cfg(
    input int         idx,
    input logic       d,
    input logic [1:0] m,
    input logic [5:0] alt,
    input logic       xt,
    input logic       pa,
    input logic       pb,
    input logic       tc
  );
    logic [3:0] c;
    c = 4'h0;
    if (idx == PIN_SEVEN) begin
      // Open-drain only, never drives high
      if (alt[ALT_XRST]) begin
        c = 4'b0011;  // R13
      end else if (m == MODE_PUSH) begin
        c = 4'b0001;  // R14
      end else if (!d) begin
        c = 4'b1000;  // R10 R11
      end else if (m == MODE_FLOAT_IN) begin
        c = 4'b0001;  // R14
      end else begin
        c = 4'b0011;  // R14
      end
    end else if (!d) begin
      c = 4'b1000;  // R2
    end else begin
      unique case (m)
        MODE_PU_IN:    c = 4'b0011;  // R1 R3
        MODE_FLOAT_IN: c = 4'b0001;  // R1
        MODE_PUSH:     c = 4'b1100;  // R2
        MODE_WAKE:     c = 4'b0011;  // R3
      endcase
    end
    // Alternate outputs take the pin push-pull
    if (idx == PIN_PWA && alt[ALT_PWA]) begin
      c = {1'b1, pa, 2'b00};  // R7 R8
    end
    if (idx == PIN_PWB) begin
      if (alt[ALT_TCO]) begin
        c = {1'b1, tc, 2'b00};  // R7 R8
      end else if (alt[ALT_PWB]) begin
        c = {1'b1, pb, 2'b00};  // R7 R8
      end
    end
    // Oscillator owns the crystal pins outright
    if (xt && alt[ALT_XTAL]) begin
      c = 4'h0;  // R9
    end
    return c;
  endfunction

  // Synchroniser for all pin inputs
  pmc_pin_sync #(
    .W       (NPIN),
    .RST_VAL ({NPIN{1'b1}})
  ) u_sync (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .async_i (pin_in_i),  // R15
    .sync_o  (pin_s)
  );

  // Bus strobes; the slave never stalls
  assign wr_en     = psel_i && penable_i && pwrite_i && addr_ok(paddr_i);
  assign rd_setup  = psel_i && !penable_i && !pwrite_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !addr_ok(paddr_i);
  assign prdata_o  = prdata_r;

  // Per-pin decode and wakeup arming
  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    assign cfg_nxt[i] = pin_cfg(i, data_r[i], mode_r[2*i+:2], alt_r, XTAL_MASK[i],
                                pulse_out_a_i, pulse_out_b_i, scaled_clock_out_i);
    // Every pin offers wakeup in mode 3 with data one, except pin seven while external reset is enabled
    assign wk_en[i] = data_r[i] && (mode_r[2*i+:2] == MODE_WAKE) &&
                      !(i == PIN_SEVEN && alt_r[ALT_XRST]);  // R7
  end

  // Data latch; both data offsets write it
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_r <= DATA_RST;
    end else if (wr_en && (paddr_i == ADDR_DATA || paddr_i == ADDR_LATCH)) begin
      data_r <= pwdata_i[NPIN-1:0];
    end
  end

  // Mode field, one pair per pin
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_r <= MODE_RST;  // R12
    end else if (wr_en && paddr_i == ADDR_MODE) begin
      mode_r <= pwdata_i[2*NPIN-1:0];  // R3
    end
  end

  // Alternate control and mask
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      alt_r  <= ALT_RST;
      mask_r <= ST_RST;
    end else if (wr_en) begin
      if (paddr_i == ADDR_ALT) begin
        alt_r <= pwdata_i[ALT_W-1:0];
      end
      if (paddr_i == ADDR_MASK) begin
        mask_r <= pwdata_i[ST_W-1:0];
      end
    end
  end

  // Registered pin drive
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      oe_r  <= '0;
      out_r <= '0;
      pu_r  <= '0;
      ie_r  <= '0;
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        {oe_r[i], out_r[i], pu_r[i], ie_r[i]} <= cfg_nxt[i];
      end
    end
  end

  assign pin_oe_o  = oe_r;
  assign pin_out_o = out_r;
  assign pin_pu_o  = pu_r;
  assign pin_ie_o  = ie_r;

  // Input gate and edge detection
  assign in_v = pin_s & ie_r;  // R1 R15
  assign fall = prev_r & ~in_v;
  assign rise = ~prev_r & in_v;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_r <= '0;
    end else begin
      prev_r <= in_v;
    end
  end

  // Interrupt events need an input mode and data one
  always_comb begin
    ev = '0;
    ev[ST_IRQ0] = (alt_r[ALT_EDG0] ? rise[PIN_IRQ0] : fall[PIN_IRQ0]) &&
                  data_r[PIN_IRQ0] && !mode_r[2*PIN_IRQ0+1];  // R8
    ev[ST_IRQ1] = fall[PIN_IRQ1] && data_r[PIN_IRQ1] && !mode_r[2*PIN_IRQ1+1];  // R8
    ev[ST_IRQ2] = fall[PIN_SEVEN] && data_r[PIN_SEVEN] &&
                  !mode_r[2*PIN_SEVEN+1] && !alt_r[ALT_XRST];  // R8
    ev[ST_WAKE] = |(fall & wk_en);  // R7
  end

  assign clr = (wr_en && paddr_i == ADDR_STAT) ? pwdata_i[ST_W-1:0] : '0;

  // Sticky status; a new event beats a clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stat_r <= ST_RST;
    end else begin
      stat_r <= (stat_r & ~clr) | ev;
    end
  end

  // Interrupt enable gates events onto the line
  assign irq_o = |(stat_r & mask_r);  // R8

  // Low on pin seven asks for reset when enabled
  assign ext_reset_req_o = alt_r[ALT_XRST] && !pin_s[PIN_SEVEN];  // R13

  // Read data captured in the setup phase
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_r <= '0;
    end else if (rd_setup) begin
      prdata_r <= '0;
      unique case (paddr_i)
        ADDR_DATA:  prdata_r[NPIN-1:0]   <= in_v;    // R5
        ADDR_LATCH: prdata_r[NPIN-1:0]   <= data_r;  // R4 R6
        ADDR_MODE:  prdata_r[2*NPIN-1:0] <= mode_r;
        ADDR_ALT:   prdata_r[ALT_W-1:0]  <= alt_r;
        ADDR_STAT:  prdata_r[ST_W-1:0]   <= stat_r;
        ADDR_MASK:  prdata_r[ST_W-1:0]   <= mask_r;
        default:    prdata_r             <= '0;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  drive_low_a: assert property (!data_r[2] && !(XTAL_MASK[2] && alt_r[ALT_XTAL])
    |=> pin_oe_o[2] && !pin_out_o[2]) else $error("pin 2 not driven low");  // R2
  push_high_a: assert property (data_r[2] && mode_r[5:4] == MODE_PUSH &&
    !(XTAL_MASK[2] && alt_r[ALT_XTAL]) |=> pin_oe_o[2] && pin_out_o[2])
    else $error("pin 2 not driven high");  // R2
  input_gate_a: assert property (pin_ie_o[4] |-> $past(data_r[4]))
    else $error("input on with data zero");  // R1
  pullup_sel_a: assert property (pin_pu_o[5] |-> $past(mode_r[11] == mode_r[10]))
    else $error("pull-up in wrong mode");  // R3
  latch_read_a: assert property (rd_setup && paddr_i == ADDR_LATCH
    |=> prdata_o == {20'h0, $past(data_r)}) else $error("latch read wrong");  // R4
  pin_read_a: assert property (rd_setup && paddr_i == ADDR_DATA
    |=> prdata_o[NPIN-1:0] == $past(in_v)) else $error("pin read wrong");  // R5
  pwm_drive_a: assert property (alt_r[ALT_PWA] && !(XTAL_MASK[1] && alt_r[ALT_XTAL])
    |=> pin_oe_o[1] && pin_out_o[1] == $past(pulse_out_a_i))
    else $error("pulse A not on pin");  // R8
  xtal_prio_a: assert property (alt_r[ALT_XTAL]
    |=> ((pin_oe_o | pin_pu_o) & XTAL_MASK) == '0) else $error("crystal pin used");  // R9
  seven_od_a: assert property (!(pin_oe_o[PIN_SEVEN] && pin_out_o[PIN_SEVEN]))
    else $error("pin 7 driven high");  // R10
  seven_low_a: assert property (!alt_r[ALT_XRST] && !data_r[PIN_SEVEN] &&
    mode_r[15:14] != MODE_PUSH |=> pin_oe_o[PIN_SEVEN]) else $error("pin 7 not low");  // R11
  seven_rst_a: assert property ($rose(rstn_i) |-> mode_r[15:14] == 2'h1)
    else $error("pin 7 mode reset wrong");  // R12
  ext_reset_a: assert property (alt_r[ALT_XRST]
    |=> pin_pu_o[PIN_SEVEN] && !pin_oe_o[PIN_SEVEN]) else $error("reset pin wrong");  // R13
  seven_float_a: assert property (!alt_r[ALT_XRST] && mode_r[15:14] == MODE_PUSH
    |=> !pin_oe_o[PIN_SEVEN] && !pin_pu_o[PIN_SEVEN] && pin_ie_o[PIN_SEVEN])
    else $error("pin 7 mode 2 wrong");  // R14
  event_set_a: assert property (ev[ST_IRQ1] |=> stat_r[ST_IRQ1] ##0 (irq_o || !mask_r[1]))
    else $error("event lost");  // R8

  wake_c: cover property (ev[ST_WAKE] ##1 irq_o);
  edge0_c: cover property (alt_r[ALT_EDG0] && ev[ST_IRQ0]);
  xreset_c: cover property (ext_reset_req_o);
  clr_set_c: cover property (clr[ST_IRQ1] && ev[ST_IRQ1]);

endmodule

//--- sim/pmc_pin_model.sv
`timescale 1ns/1ps
// External circuitry on the port pins: pull-ups, floating lines and an outside source
module pmc_pin_model
  import pmc_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic [NPIN-1:0] out_i,  // Device output value
  input  wire logic [NPIN-1:0] oe_i,   // Device drives the pin
  input  wire logic [NPIN-1:0] pu_i,   // Device pull-up on
  input  wire logic [NPIN-1:0] drv_i,  // Outside source drives the pin
  input  wire logic [NPIN-1:0] val_i,  // Level of the outside source
  output logic      [NPIN-1:0] lvl_o   // Resolved wire level
);
  logic [NPIN-1:0] flt_r = 12'h555;  // Undriven lines wander every cycle

  // A free line never keeps its last value, so the synchroniser never accepts it and keeps the last agreed level
  always @(posedge clk_i) begin
    flt_r <= ~flt_r;
  end

  // Device drive first, then the outside source, then the pull-up
  assign lvl_o = (oe_i & out_i) | (~oe_i & drv_i & val_i) | (~oe_i & ~drv_i & (pu_i | flt_r));
endmodule

//--- sim/port_pin_mode_control_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the port pin block
module port_pin_mode_control_bench;
  import pmc_pkg::*;
  logic clk_i = 1'b0, rstn_i = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0]      paddr = 8'h00;    // Bus address
  logic [31:0]     pwdata = 32'h0;   // Bus write data
  logic [31:0]     prdata, rd;       // Read data, last read word
  logic            pready, pslverr, irq, xreq, err;
  logic            pa = 1'b0, pb = 1'b0, tc = 1'b0;  // Alternate sources
  logic [NPIN-1:0] pin_in, pout, poe, ppu, pie;
  logic [NPIN-1:0] drv = 12'h000, val = 12'h000;     // Outside source
  int              num_errors = 0, checks = 0;

  // Clock at 200 MHz
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  pmc_port dut (.clk_i(clk_i), .rstn_i(rstn_i), .paddr_i(paddr), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .pin_in_i(pin_in), .pin_out_o(pout),
    .pin_oe_o(poe), .pin_pu_o(ppu), .pin_ie_o(pie), .pulse_out_a_i(pa),
    .pulse_out_b_i(pb), .scaled_clock_out_i(tc), .irq_o(irq), .ext_reset_req_o(xreq));
  pmc_pin_model ext (.clk_i(clk_i), .out_i(pout), .oe_i(poe), .pu_i(ppu),
    .drv_i(drv), .val_i(val), .lvl_o(pin_in));

  // Verdict and end of run
  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Word comparison
  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Single bit comparison
  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_reg(n, {31'h0, e}, {31'h0, g});
  endtask

  // One APB transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // Let pin outputs and synchronisers settle
  task automatic settle();
    repeat (6) @(posedge clk_i);
    #1;
  endtask

  // Expected {oe, out, pu, ie} for a pin in mode m with data d
  function automatic logic [3:0] pexp(input logic sev, input logic [1:0] m, input logic d);
    if (sev && m == 2'h2) return 4'b0001;
    if (!d) return 4'b1000;
    case (m)
      2'h0: return 4'b0011;
      2'h1: return 4'b0001;
      2'h2: return 4'b1100;
      default: return 4'b0011;
    endcase
  endfunction

  // Reset state of pins and registers
  task automatic t_reset();
    settle();
    chk_reg("oe", 32'h0, {20'h0, poe});
    chk_reg("pu", 32'h00000f7f, {20'h0, ppu});
    apb(1'b0, ADDR_MODE, 32'h0);
    chk_reg("mode", 32'h00004000, rd);
    apb(1'b0, ADDR_ALT, 32'h0);
    chk_reg("alt", 32'h0, rd);
  endtask

  // Every mode and data value on a plain pin and on pin seven
  task automatic t_modes();
    logic [3:0] e;
    int p;
    for (int k = 0; k < 2; k++) begin
      p = k ? PIN_SEVEN : 2;
      for (int m = 0; m < 4; m++) begin
        for (int d = 0; d < 2; d++) begin
          apb(1'b1, ADDR_MODE, {8'h0, MODE_RST} & ~(32'h3 << 2 * p) | (m << 2 * p));
          apb(1'b1, ADDR_DATA, {20'h0, ~(12'h1 << p)} | (d << p));
          settle();
          e = pexp(k == 1, m[1:0], d[0]);
          chk_bit("oe", e[3], poe[p]);
          if (e[3]) chk_bit("out", e[2], pout[p]);
          chk_bit("pu", e[1], ppu[p]);
          chk_bit("ie", e[0], pie[p]);
          chk_bit("pu other", 1'b1, ppu[4]);
        end
      end
    end
    apb(1'b1, ADDR_MODE, {8'h0, MODE_RST});
    apb(1'b1, ADDR_DATA, 32'h00000fff);
  endtask

  // Pin state read versus output latch read
  task automatic t_read();
    drv <= 12'h200;
    settle();
    apb(1'b0, ADDR_DATA, 32'h0);
    chk_bit("pin read", 1'b0, rd[9]);
    apb(1'b0, ADDR_LATCH, 32'h0);
    chk_bit("latch read", 1'b1, rd[9]);
    apb(1'b1, ADDR_LATCH, 32'h00000dff);
    apb(1'b0, ADDR_LATCH, 32'h0);
    chk_reg("latch", 32'h00000dff, rd);
    drv <= 12'h000;
    apb(1'b1, ADDR_DATA, 32'h00000fff);
  endtask

  // Alternate outputs, priority of scaled clock, crystal override
  task automatic t_alt();
    for (int v = 0; v < 2; v++) begin
      pa <= v[0];
      pb <= v[0];
      tc <= ~v[0];
      apb(1'b1, ADDR_ALT, 32'h1);
      settle();
      chk_bit("pwa oe", 1'b1, poe[PIN_PWA]);
      chk_bit("pwa out", v[0], pout[PIN_PWA]);
      apb(1'b1, ADDR_ALT, 32'h2);
      settle();
      chk_bit("pwb out", v[0], pout[PIN_PWB]);
      apb(1'b1, ADDR_ALT, 32'h6);
      settle();
      chk_bit("tco out", ~v[0], pout[PIN_PWB]);
    end
    apb(1'b1, ADDR_MODE, {8'h0, MODE_RST} | 32'h800);
    apb(1'b1, ADDR_ALT, 32'h10);
    settle();
    chk_bit("xtal oe", 1'b0, poe[5]);
    apb(1'b1, ADDR_ALT, 32'h0);
    apb(1'b1, ADDR_MODE, {8'h0, MODE_RST});
  endtask

  // Falling edge on PB0: latency, status, mask and clear
  task automatic t_irq();
    logic hit;
    apb(1'b1, ADDR_MASK, 32'h2);
    @(posedge clk_i);
    val <= 12'h000;
    drv <= 12'h100;
    repeat (3) @(posedge clk_i);
    #1;
    chk_bit("irq early", 1'b0, irq);
    hit = 1'b0;
    for (int i = 0; i < 20 && !hit; i++) begin
      @(posedge clk_i);
      #1;
      hit = (irq === 1'b1);
    end
    chk_bit("irq", 1'b1, hit);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk_reg("stat", 32'h2, rd & 32'h7);
    apb(1'b1, ADDR_STAT, 32'h2);
    settle();
    chk_bit("irq clr", 1'b0, irq);
    drv <= 12'h000;
    settle();
    // Wakeup mode is not an interrupt input mode
    apb(1'b1, ADDR_MODE, {8'h0, MODE_RST} | 32'h30000);
    drv <= 12'h100;
    settle();
    apb(1'b0, ADDR_STAT, 32'h0);
    chk_bit("wake no irq", 1'b0, rd[1]);
    chk_bit("wake set", 1'b1, rd[3]);
    chk_bit("irq masked", 1'b0, irq);
    drv <= 12'h000;
    apb(1'b1, ADDR_MODE, {8'h0, MODE_RST});
    apb(1'b1, ADDR_STAT, 32'hf);
  endtask

  // Rising edge mode on PA0, falling edge on pin seven
  task automatic t_edge();
    apb(1'b1, ADDR_ALT, 32'h20);
    apb(1'b1, ADDR_MASK, 32'h1);
    drv <= 12'h001;
    settle();
    apb(1'b0, ADDR_STAT, 32'h0);
    chk_bit("irq0 fall", 1'b0, rd[0]);
    drv <= 12'h000;
    settle();
    chk_bit("irq0 rise", 1'b1, irq);
    drv <= 12'h080;
    settle();
    apb(1'b0, ADDR_STAT, 32'h0);
    chk_reg("irq2", 32'h5, rd & 32'h7);
    apb(1'b1, ADDR_STAT, 32'hf);
    apb(1'b1, ADDR_ALT, 32'h0);
  endtask

  // External reset use of pin seven, and an unmapped offset
  task automatic t_misc();
    apb(1'b1, ADDR_ALT, 32'h8);
    apb(1'b1, ADDR_DATA, 32'h00000f7f);
    drv <= 12'h080;
    settle();
    chk_bit("xrst pu", 1'b1, ppu[PIN_SEVEN]);
    chk_bit("xrst oe", 1'b0, poe[PIN_SEVEN]);
    chk_bit("xrst req", 1'b1, xreq);
    apb(1'b0, 8'h18, 32'h0);
    chk_bit("slverr", 1'b1, err);
    chk_reg("unmapped", 32'h0, rd);
  endtask

  // Watchdog
  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_modes();
    t_read();
    t_alt();
    t_irq();
    t_edge();
    t_misc();
    wrap_up();
  end
endmodule
